// ---- rtl/cmb_mailbox_ctrl.sv ----
// cmb_mailbox_ctrl: mailbox ram, enable/direction/request registers,
// transmit arbitration and frame completion bookkeeping.
// assumes a bit engine outside that asks for bytes and reports results.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
// Summary of operation
// - receive mailbox data bytes are cpu read-only
// - eight data bytes at offsets 06h..0dh
// - transmit byte count follows data length code
// - reception stores incoming data length code
// - success loads time stamp into word 0eh
// - failed attempts leave time stamp unchanged
// - per-mailbox enable bit, reset zero
// - disabling mid-transmit may still complete frame
// - auto-reply control writes need enable clear
// - per-mailbox direction bit, zero means transmit
// - last mailbox direction reads one always
// - rx switched to tx: pending, no irq
// - tx switched to rx: ack, no irq
// - send when requested, enabled, transmit direction
// - order select zero: lowest number first
// - order select one: highest id priority first
// - lost arbitration triggers fresh arbitration
// - request cleared on successful transmission
// - failed transmission retried until success
// - writes rejected while request bit set
// - request set only for transmit mailboxes
// - sixteen mailboxes of sixteen bytes each
module cmb_mailbox_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] stamp_count,
   input wire logic eng_idle,
   output logic tx_start,
   output logic [3:0] tx_mbox,
   output logic [31:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic tx_remote,
   input wire logic [2:0] tx_byte_sel,
   output logic [7:0] tx_byte,
   input wire logic tx_done_ok,
   input wire logic tx_done_fail,
   input wire logic rx_done_ok,
   input wire logic [3:0] rx_mbox,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   output logic [15:0] tx_ack_set,
   output logic [15:0] rx_pend_set,
   output logic [15:0] tx_irq_set,
   output logic [15:0] rx_irq_set
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // sixteen boxes
   logic [15:0] mbox_ram [0:127]; // 16 boxes x 8 half-words
   logic [15:0] enable; // per-box enable
   logic [15:0] direction; // bit 15 is fixed high
   logic [15:0] tx_req; // bit 15 never set
   logic [7:0] master_ctrl; // only order select is live
   logic busy; // a frame owns the engine
   logic [3:0] cur_mbox; // mailbox of frame in flight
   logic cur_dir_tx; // direction at start of frame
   logic arb_found;
   logic [3:0] arb_pick;
   logic [255:0] id_keys;
   logic [15:0] eligible;
   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic acc; // access phase
   logic wr; // write takes effect this edge
   logic in_mbox;
   logic [3:0] a_box;
   logic [2:0] a_word;
   logic [31:0] rd_val;
   logic known;
   logic wr_allowed;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pready = 1'b1; // zero wait states
   assign in_mbox = (paddr >= {cmb_pkg::MBOX_BASE[13:0], 2'b00}) &&
                    (paddr <= {cmb_pkg::MBOX_END[13:0], 2'b00});
   assign a_box = paddr[9:6];
   assign a_word = paddr[5:3];

   // auto-reply flag lives in the control half-word
   function automatic logic auto_reply(input logic [15:0] ctrl);
      return ctrl[cmb_pkg::AUTO_REPLY_BIT];
   endfunction

   // register index to its word-aligned byte address
   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] idx);
      return a == {idx[13:0], 2'b00};
   endfunction

   // cpu write filter for one mailbox half-word
   always_comb begin
      wr_allowed = 1'b1;
      if (tx_req[a_box])
         wr_allowed = 1'b0;
      else if (direction[a_box] && a_word >= cmb_pkg::W_DATA01 &&
               a_word <= cmb_pkg::W_DATA67)
         wr_allowed = 1'b0;
      else if (a_word == cmb_pkg::W_CTRL && enable[a_box] &&
               auto_reply(mbox_ram[{a_box, cmb_pkg::W_CTRL}]))
         wr_allowed = 1'b0;
      else if (a_word == cmb_pkg::W_STAMP)
         wr_allowed = 1'b0;
   end

   // read mux; unmapped addresses answer zero with an error
   always_comb begin
      rd_val = 32'h0000_0000;
      known = 1'b1;
      if (in_mbox)
         rd_val = {16'h0000, mbox_ram[{a_box, a_word}]};
      else if (hit(paddr, cmb_pkg::IDX_ENABLE_LOW))
         rd_val = {24'h000000, enable[7:0]};
      else if (hit(paddr, cmb_pkg::IDX_ENABLE_HIGH))
         rd_val = {24'h000000, enable[15:8]};
      else if (hit(paddr, cmb_pkg::IDX_DIR_LOW))
         rd_val = {24'h000000, direction[7:0]};
      else if (hit(paddr, cmb_pkg::IDX_DIR_HIGH))
         rd_val = {24'h000000, direction[15:8]};
      else if (hit(paddr, cmb_pkg::IDX_TXREQ_LOW))
         rd_val = {24'h000000, tx_req[7:0]};
      else if (hit(paddr, cmb_pkg::IDX_TXREQ_HIGH))
         rd_val = {24'h000000, tx_req[15:8]};
      else if (hit(paddr, cmb_pkg::IDX_MASTER_CTRL))
         rd_val = {24'h000000, master_ctrl};
      else if (hit(paddr, cmb_pkg::IDX_STAMP_CNT))
         rd_val = {16'h0000, stamp_count};
      else
         known = 1'b0;
   end

   // registered read data, combinational error flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end
   assign pslverr = acc && !known;

   // ------------------------------------------------------------
   // enable, direction, master control
   // ------------------------------------------------------------
   // enable write, reset zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= {cmb_pkg::ENABLE_RST, cmb_pkg::ENABLE_RST};
      end else if (wr && pstrb[0]) begin
         if (hit(paddr, cmb_pkg::IDX_ENABLE_LOW))
            enable[7:0] <= pwdata[7:0];
         if (hit(paddr, cmb_pkg::IDX_ENABLE_HIGH))
            enable[15:8] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direction <= {cmb_pkg::DIR_HIGH_RST, cmb_pkg::DIR_LOW_RST};
      end else if (wr && pstrb[0]) begin
         if (hit(paddr, cmb_pkg::IDX_DIR_LOW))
            direction[7:0] <= pwdata[7:0];
         if (hit(paddr, cmb_pkg::IDX_DIR_HIGH))
            direction[15:8] <= {1'b1, pwdata[6:0]};
      end
   end

   // master control; only order select steers logic here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_ctrl <= 8'h00;
      end else if (wr && pstrb[0] &&
                   hit(paddr, cmb_pkg::IDX_MASTER_CTRL)) begin
         master_ctrl <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // transmit request bits
   // ------------------------------------------------------------
   logic [15:0] req_wr_ones;
   always_comb begin
      req_wr_ones = 16'h0000;
      if (wr && pstrb[0]) begin
         if (hit(paddr, cmb_pkg::IDX_TXREQ_LOW))
            req_wr_ones[7:0] = pwdata[7:0];
         if (hit(paddr, cmb_pkg::IDX_TXREQ_HIGH))
            req_wr_ones[15:8] = {1'b0, pwdata[6:0]};
      end
   end

   // set wins over the completion clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_req <= {cmb_pkg::TXREQ_RST, cmb_pkg::TXREQ_RST};
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (req_wr_ones[i] && !direction[i])
               tx_req[i] <= 1'b1;
            else if (busy && cur_dir_tx && tx_done_ok &&
                     cur_mbox == 4'(i))
               tx_req[i] <= 1'b0;
         end
         tx_req[cmb_pkg::LAST_MBOX] <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // internal arbitration
   // ------------------------------------------------------------
   // identifier key: the upper word alone, lower word not used;
   // leading zeros give the highest bus priority
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         id_keys[i*16 +: 16] = mbox_ram[{4'(i), cmb_pkg::W_ID_UPPER}];
      end
   end
   assign eligible = tx_req & enable & ~direction;

   cmb_arbiter u_arb (
      .pending(eligible),
      .order_by_id(master_ctrl[cmb_pkg::ORDER_SEL_BIT]),
      .id_keys(id_keys),
      .found(arb_found),
      .pick(arb_pick)
   );

   // frame ownership; each start runs a fresh pick, so a higher-priority box
   // requested meanwhile or after a lost arbitration goes next
   // re-arbitrate every frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cur_mbox <= 4'h0;
         cur_dir_tx <= 1'b0;
      end else if (!busy) begin
         if (arb_found && eng_idle) begin
            busy <= 1'b1;
            cur_mbox <= arb_pick;
            cur_dir_tx <= 1'b1;
         end
      end else if (tx_done_ok || tx_done_fail) begin
         busy <= 1'b0;
      end
   end
   assign tx_start = !busy && arb_found && eng_idle;

   // frame description to the engine, latched at start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mbox <= 4'h0;
         tx_id <= 32'h0000_0000;
         tx_dlc <= 4'h0;
         tx_remote <= 1'b0;
      end else if (tx_start) begin
         tx_mbox <= arb_pick;
         tx_id <= {mbox_ram[{arb_pick, cmb_pkg::W_ID_UPPER}],
                   mbox_ram[{arb_pick, cmb_pkg::W_ID_LOWER}]};
         tx_dlc <= mbox_ram[{arb_pick, cmb_pkg::W_CTRL}][3:0];
         tx_remote <= mbox_ram[{arb_pick, cmb_pkg::W_CTRL}][4];
      end
   end

   logic [15:0] tx_half;
   assign tx_half = mbox_ram[{tx_mbox, 3'(3'(tx_byte_sel >> 1) + 3'h3)}];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_byte <= 8'h00;
      end else begin
         tx_byte <= tx_byte_sel[0] ? tx_half[15:8] : tx_half[7:0];
      end
   end

   // ------------------------------------------------------------
   // completion events
   // ------------------------------------------------------------
   // flags follow the direction now, not at frame start, so a box
   // switched mid-frame completes silently without interrupt
   // silent completion
   always_comb begin
      tx_ack_set = 16'h0000;
      rx_pend_set = 16'h0000;
      tx_irq_set = 16'h0000;
      rx_irq_set = 16'h0000;
      if (busy && tx_done_ok) begin
         tx_ack_set[cur_mbox] = 1'b1;
         tx_irq_set[cur_mbox] = !direction[cur_mbox];
      end
      if (rx_done_ok) begin
         rx_pend_set[rx_mbox] = 1'b1;
         rx_irq_set[rx_mbox] = direction[rx_mbox];
      end
   end

   // ------------------------------------------------------------
   // mailbox ram writes
   // ------------------------------------------------------------
   // cpu never writes the stamp word, so only a reception beats it
   always_ff @(posedge pclk) begin
      if (busy && tx_done_ok) begin
         mbox_ram[{cur_mbox, cmb_pkg::W_STAMP}] <= stamp_count;
      end
      if (rx_done_ok) begin
         mbox_ram[{rx_mbox, cmb_pkg::W_CTRL}] <=
            {mbox_ram[{rx_mbox, cmb_pkg::W_CTRL}][15:4], rx_dlc};
         for (int k = 0; k < 4; k++) begin
            mbox_ram[{rx_mbox, 3'(k + 3)}] <= rx_data[k*16 +: 16];
         end
         mbox_ram[{rx_mbox, cmb_pkg::W_STAMP}] <= stamp_count;
      end else if (wr && in_mbox && wr_allowed) begin
         mbox_ram[{a_box, a_word}] <= pwdata[15:0];
      end
   end
endmodule // cmb_mailbox_ctrl

// ---- rtl/cmb_pkg.sv ----
// cmb_pkg: register map, mailbox layout and field constants for the
// can mailbox transmit control block.
// assumes an apb slave with 32-bit data, one register per aligned word.
package cmb_pkg;
   // ------------------------------------------------------------
   // mailbox geometry
   // ------------------------------------------------------------
   localparam int unsigned NUM_MBOX = 16;
   localparam int unsigned LAST_MBOX = 15;
   localparam int unsigned MBOX_BYTES = 16;
   localparam int unsigned MBOX_WORDS = 8;
   // mailbox region first and last index
   localparam logic [15:0] MBOX_BASE = 16'h2200;
   localparam logic [15:0] MBOX_END = 16'h22ff;
   // 16-bit word index within a mailbox (byte offset / 2)
   localparam logic [2:0] W_ID_UPPER = 3'h0;
   localparam logic [2:0] W_ID_LOWER = 3'h1;
   localparam logic [2:0] W_CTRL = 3'h2;
   localparam logic [2:0] W_DATA01 = 3'h3;
   localparam logic [2:0] W_DATA67 = 3'h6;
   localparam logic [2:0] W_STAMP = 3'h7;
   // ------------------------------------------------------------
   // control register indices; byte address is four times each
   // ------------------------------------------------------------
   localparam logic [15:0] IDX_ENABLE_LOW = 16'h2300;
   localparam logic [15:0] IDX_ENABLE_HIGH = 16'h2301;
   localparam logic [15:0] IDX_DIR_LOW = 16'h2302;
   localparam logic [15:0] IDX_DIR_HIGH = 16'h2303;
   localparam logic [15:0] IDX_TXREQ_LOW = 16'h2304;
   localparam logic [15:0] IDX_TXREQ_HIGH = 16'h2305;
   localparam logic [15:0] IDX_MASTER_CTRL = 16'h2318;
   localparam logic [15:0] IDX_STAMP_CNT = 16'h2332;
   localparam logic [15:0] IDX_TX_ACK = 16'h2308;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned ORDER_SEL_BIT = 3;
   localparam int unsigned AUTO_REPLY_BIT = 5;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] DIR_LOW_RST = 8'h00;
   localparam logic [7:0] DIR_HIGH_RST = 8'h80;
   localparam logic [7:0] TXREQ_RST = 8'h00;
   localparam logic [3:0] DLC_MAX = 4'h8;
endpackage : cmb_pkg

// ---- rtl/cmb_arbiter.sv ----
// cmb_arbiter: picks the next mailbox to send among pending requests.
// assumes request vector and stored identifiers are stable for a cycle.
`timescale 1ns/10ps
module cmb_arbiter (
   input wire logic [15:0] pending,
   input wire logic order_by_id,
   input wire logic [255:0] id_keys,
   output logic found,
   output logic [3:0] pick
);
   // ------------------------------------------------------------
   // priority search
   // ------------------------------------------------------------
   // lower key wins; with order_by_id low the index is the key, so
   // the same loop serves both orders and ties go to the lower box
   always_comb begin
      logic [15:0] best_key;
      logic [15:0] key;
      best_key = 16'hffff;
      key = 16'h0000;
      found = 1'b0;
      pick = 4'h0;
      for (int i = 0; i < 16; i++) begin
         key = order_by_id ? id_keys[i*16 +: 16] : 16'(i);
         if (pending[i] && (!found || key < best_key)) begin
            found = 1'b1;
            best_key = key;
            pick = 4'(i);
         end
      end
   end
endmodule // cmb_arbiter

// ---- dv/cmb_mailbox_checker.sv ----
// cmb_mailbox_checker: port-level checks on the mailbox block.
// assumes it is bound into cmb_mailbox_ctrl; one clock, async reset.
`timescale 1ns/10ps
module cmb_mailbox_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic eng_idle,
   input wire logic tx_start,
   input wire logic [3:0] tx_mbox,
   input wire logic tx_done_ok,
   input wire logic tx_done_fail,
   input wire logic rx_done_ok,
   input wire logic [3:0] rx_mbox,
   input wire logic [15:0] tx_ack_set,
   input wire logic [15:0] rx_pend_set,
   input wire logic [15:0] tx_irq_set,
   input wire logic [15:0] rx_irq_set
);
   // ------------------------------------------------------------
   // frame tracking
   // ------------------------------------------------------------
   // high from frame start to its end pulse, one frame at a time
   logic busy_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         busy_q <= 1'b0;
      else if (tx_start)
         busy_q <= 1'b1;
      else if (tx_done_ok || tx_done_fail)
         busy_q <= 1'b0;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_start_free; tx_start |-> eng_idle && !busy_q; endproperty
   a_start_free: assert property (p_start_free)
      else $error("frame start while engine busy");
   property p_no_last; tx_start |=> tx_mbox != 4'hf; endproperty
   a_no_last: assert property (p_no_last)
      else $error("receive-only mailbox sent");
   property p_ack_ok; tx_done_ok && busy_q |-> $onehot(tx_ack_set); endproperty
   a_ack_ok: assert property (p_ack_ok)
      else $error("no single acknowledge on success");
   property p_ack_cause; tx_ack_set != 16'h0 |-> tx_done_ok; endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("acknowledge without success");
   property p_retry; tx_done_fail |-> ##[1:300] tx_start; endproperty
   a_retry: assert property (p_retry)
      else $error("failed frame not retried");
   property p_tx_irq; (tx_irq_set & ~tx_ack_set) == 16'h0; endproperty
   a_tx_irq: assert property (p_tx_irq)
      else $error("transmit flag without acknowledge");
   property p_rx_pend; rx_done_ok |-> rx_pend_set == 16'h1 << rx_mbox;
   endproperty
   a_rx_pend: assert property (p_rx_pend)
      else $error("receive pending not set");
   property p_rx_irq; (rx_irq_set & ~rx_pend_set) == 16'h0; endproperty
   a_rx_irq: assert property (p_rx_irq)
      else $error("receive flag without pending");
   c_fail: cover property (tx_done_fail);
   c_rx: cover property (rx_done_ok);
   c_two: cover property (tx_start ##[1:200] tx_start);
endmodule // cmb_mailbox_checker

// ---- dv/cmb_engine_model.sv ----
// cmb_engine_model: behavioural bit engine beyond the mailbox block.
// assumes tx_* stand from the cycle after tx_start until the end pulse.
`timescale 1ns/10ps
module cmb_engine_model (
   input wire logic pclk,
   input wire logic tx_start,
   input wire logic [3:0] tx_mbox,
   input wire logic [3:0] tx_dlc,
   input wire logic [7:0] tx_byte,
   input wire logic [15:0] stamp_count,
   input wire logic [4:0] gap,
   input wire logic [1:0] fail_req,
   output logic eng_idle,
   output logic [2:0] tx_byte_sel,
   output logic tx_done_ok,
   output logic tx_done_fail,
   output logic [3:0] fm_mbox,
   output logic [3:0] fm_dlc,
   output logic [63:0] fm_data,
   output logic [15:0] fm_stamp,
   output int tries
);
   // ------------------------------------------------------------
   // frame engine
   // ------------------------------------------------------------
   // one frame at a time; fail_req attempts lose before each success
   initial begin
      logic [63:0] d;
      int nf;
      nf = 0;
      tries = 0;
      {eng_idle, tx_byte_sel, tx_done_ok, tx_done_fail} = 6'h20;
      forever begin
         @(posedge pclk);
         if (tx_start === 1'b1) begin
            eng_idle <= 1'b0;
            repeat (2) @(posedge pclk);
            d = '0;
            for (int i = 0; i < 8 && i < tx_dlc; i++) begin
               tx_byte_sel <= 3'(i);
               repeat (2) @(posedge pclk);
               d[i*8 +: 8] = tx_byte;
            end
            repeat (gap) @(posedge pclk);
            tries++;
            if (nf < fail_req) begin
               nf++;
               tx_done_fail <= 1'b1;
            end else begin
               nf = 0;
               tx_done_ok <= 1'b1;
            end
            @(posedge pclk);
            // the block loads the stamp it sees at this edge
            if (tx_done_ok) begin
               {fm_mbox, fm_dlc, fm_data} <= {tx_mbox, tx_dlc, d};
               fm_stamp <= stamp_count;
            end
            {tx_done_ok, tx_done_fail, eng_idle} <= 3'h1;
            tx_byte_sel <= ~tx_byte_sel;
         end
      end
   end
endmodule // cmb_engine_model

// ---- dv/cmb_mailbox_ctrl_test.sv ----
// cmb_mailbox_ctrl_test: self-checking bench for the mailbox block.
// assumes the engine model beside it and the checker bound below.
`timescale 1ns/10ps
module cmb_mailbox_ctrl_test;
   // ------------------------------------------------------------
   // signals and expected state
   // ------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic eng_idle, tx_start, tx_done_ok, tx_done_fail, rx_done_ok;
   logic [15:0] paddr, stamp_count, fm_stamp;
   logic [31:0] pwdata, prdata;
   logic [3:0] tx_mbox, tx_dlc, rx_mbox, rx_dlc, fm_mbox, fm_dlc;
   logic [2:0] tx_byte_sel;
   logic [7:0] tx_byte;
   logic [63:0] rx_data, fm_data;
   logic [4:0] gap;
   logic [1:0] fail_req;
   logic [15:0] mem [16][8]; // expected mailbox words
   int dlc [16]; // expected length codes
   int tries, bad_count, num_checks;
   cmb_mailbox_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stamp_count(stamp_count), .eng_idle(eng_idle), .tx_start(tx_start),
      .tx_mbox(tx_mbox), .tx_id(), .tx_dlc(tx_dlc), .tx_remote(),
      .tx_byte_sel(tx_byte_sel), .tx_byte(tx_byte), .tx_done_ok(tx_done_ok),
      .tx_done_fail(tx_done_fail), .rx_done_ok(rx_done_ok),
      .rx_mbox(rx_mbox), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .tx_ack_set(), .rx_pend_set(), .tx_irq_set(), .rx_irq_set());
   cmb_engine_model u_eng (.pclk(pclk), .tx_start(tx_start),
      .tx_mbox(tx_mbox), .tx_dlc(tx_dlc), .tx_byte(tx_byte),
      .stamp_count(stamp_count), .gap(gap), .fail_req(fail_req),
      .eng_idle(eng_idle), .tx_byte_sel(tx_byte_sel), .tx_done_ok(tx_done_ok),
      .tx_done_fail(tx_done_fail), .fm_mbox(fm_mbox), .fm_dlc(fm_dlc),
      .fm_data(fm_data), .fm_stamp(fm_stamp), .tries(tries));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // free time stamp counter seen by the block
   always @(posedge pclk) stamp_count <= stamp_count + 16'h1;
   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      num_checks++;
      if (g !== x) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   // one apb transfer to register index a; entered after a rising edge
   task automatic apb(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a << 2, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) begin
         bad_count++;
         close_out;
      end
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [15:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q[15:0], x);
   endtask
   function automatic logic [15:0] mb(input int n, input int w);
      return cmb_pkg::MBOX_BASE + 16'(n * 16 + w * 2);
   endfunction
   task automatic load(input int n, input logic [15:0] id);
      dlc[n] = $urandom_range(8);
      wr(mb(n, 0), {16'h0, id});
      wr(mb(n, 2), 32'(dlc[n]));
      for (int w = 3; w < 7; w++) begin
         mem[n][w] = 16'($urandom);
         wr(mb(n, w), {16'h0, mem[n][w]});
      end
   endtask
   // waits for the next success, then checks mailbox, bytes and stamp
   task automatic expect_frame(input int n);
      logic [63:0] x;
      int k;
      k = 0;
      while (tx_done_ok !== 1'b1 && k < 4000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 4000) begin
         bad_count++;
         close_out;
      end
      @(posedge pclk);
      x = '0;
      for (int i = 0; i < dlc[n]; i++)
         x[i*8 +: 8] = mem[n][3 + i/2][(i%2)*8 +: 8];
      chk(fm_mbox, n);
      chk(fm_dlc, dlc[n]);
      chk(fm_data, x);
      rdc(mb(n, 7), fm_stamp);
      $display("frame from mailbox %0d checked", n);
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      close_out;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      logic [15:0] st;
      {psel, penable, pwrite, rx_done_ok, presetn, fail_req} = '0;
      {paddr, pwdata, rx_data, rx_mbox, rx_dlc, stamp_count} = '0;
      {gap, bad_count, num_checks} = '0;
      void'($urandom(39));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(cmb_pkg::IDX_ENABLE_LOW, 16'h0);
      rdc(cmb_pkg::IDX_ENABLE_HIGH, 16'h0);
      rdc(cmb_pkg::IDX_DIR_LOW, 16'h0);
      rdc(cmb_pkg::IDX_DIR_HIGH, 16'h80);
      rdc(cmb_pkg::IDX_TXREQ_LOW, 16'h0);
      apb(1'b0, 16'h2306, 32'h0, q, e);
      chk(e, 1'b1);
      wr(cmb_pkg::IDX_DIR_HIGH, 32'h0);
      rdc(cmb_pkg::IDX_DIR_HIGH, 16'h80);
      wr(cmb_pkg::IDX_DIR_LOW, 32'h8);
      rdc(cmb_pkg::IDX_DIR_LOW, 16'h08);
      wr(cmb_pkg::IDX_ENABLE_LOW, 32'h2e);
      rdc(cmb_pkg::IDX_ENABLE_LOW, 16'h2e);
      $display("test registers done");
      // reception into receive mailbox 3, then a refused cpu write
      {rx_mbox, rx_dlc, rx_data} <= {4'h3, 4'h8, $urandom, $urandom};
      rx_done_ok <= 1'b1;
      @(posedge pclk);
      st = stamp_count;
      rx_done_ok <= 1'b0;
      @(posedge pclk);
      for (int w = 3; w < 7; w++)
         rdc(mb(3, w), rx_data[(w-3)*16 +: 16]);
      apb(1'b0, mb(3, 2), 32'h0, q, e);
      chk(q[3:0], 4'h8);
      rdc(mb(3, 7), st);
      wr(mb(3, 3), {16'h0, ~rx_data[15:0]});
      rdc(mb(3, 3), rx_data[15:0]);
      $display("test receive done");
      // lower request arriving mid-frame goes next
      gap <= 5'(16 + $urandom_range(15));
      load(2, 16'h0);
      load(5, 16'h0);
      load(1, 16'h0);
      wr(cmb_pkg::IDX_TXREQ_LOW, 32'h24);
      wr(cmb_pkg::IDX_TXREQ_LOW, 32'h02);
      expect_frame(2);
      expect_frame(1);
      expect_frame(5);
      rdc(cmb_pkg::IDX_TXREQ_LOW, 16'h0);
      $display("test number order done");
      // identifier order, each frame losing once first
      wr(cmb_pkg::IDX_MASTER_CTRL, 32'h8);
      gap <= 5'(4 + $urandom_range(8));
      wr(cmb_pkg::IDX_ENABLE_LOW, 32'h0);
      load(1, 16'h0100);
      load(2, 16'h0010);
      wr(cmb_pkg::IDX_ENABLE_LOW, 32'h2e);
      st = 16'(tries);
      fail_req <= 2'h1;
      wr(cmb_pkg::IDX_TXREQ_LOW, 32'h06);
      expect_frame(2);
      expect_frame(1);
      chk(16'(tries) - st, 16'h4);
      fail_req <= 2'h0;
      $display("test identifier order done");
      // disabled mailbox keeps its request and locks its data
      load(7, 16'h0);
      wr(cmb_pkg::IDX_TXREQ_LOW, 32'h88);
      rdc(cmb_pkg::IDX_TXREQ_LOW, 16'h80);
      wr(mb(7, 3), {16'h0, ~mem[7][3]});
      rdc(mb(7, 3), mem[7][3]);
      wr(cmb_pkg::IDX_TXREQ_LOW, 32'h0);
      rdc(cmb_pkg::IDX_TXREQ_LOW, 16'h80);
      wr(cmb_pkg::IDX_ENABLE_LOW, 32'hae);
      expect_frame(7);
      rdc(cmb_pkg::IDX_TXREQ_LOW, 16'h0);
      $display("test locked request done");
      close_out;
   end
endmodule // cmb_mailbox_ctrl_test
bind cmb_mailbox_ctrl cmb_mailbox_checker u_chk (.pclk(pclk),
   .presetn(presetn), .eng_idle(eng_idle), .tx_start(tx_start),
   .tx_mbox(tx_mbox), .tx_done_ok(tx_done_ok), .tx_done_fail(tx_done_fail),
   .rx_done_ok(rx_done_ok), .rx_mbox(rx_mbox), .tx_ack_set(tx_ack_set),
   .rx_pend_set(rx_pend_set), .tx_irq_set(tx_irq_set),
   .rx_irq_set(rx_irq_set));
